// *** hdl/hippi_dest_status.sv ***
// Status, error checking and end-address queue of a link destination.
// Assumes link_clk is the source clock inverted at the pin, so its
// rising edge is the source falling edge; commands are one-cycle strobes.
`default_nettype none
`include "hippi_dest_map.svh"
// Operation
// - Loopback bit; source clear leaves loopback
// - Wide bit drives cable-B out; clear sets
// - Completion at 63 pending: overflow, drop connect
// - Odd parity per byte; fatal flag
// - Sequence flag on hierarchy violations
// - Only request-false, burst-without-packet drop connect
// - Sequence and parity positions swap by capability
// - LLRC compare at burst end; fatal flag
// - Burst over 256 periods is fatal
// - Second short burst per packet is fatal
// - Request falling while connected: disconnect flag
// - Buffer stack parity flag, no side effects
// - Word at full busy FIFO: overflow
// - Lost command conditions per function
// - Commands run during data; lost clears
// - Packet level reported; interrupt after queue entry
// - Report request, connect, cable-B in on master; request interrupts
// - Buffer half bit; interrupt on change
// - Pending count saturates 63; pop decrements
// - Ready count adds to 32; burst end subtracts
// - End-address FIFO, each entry read once
// - Entry parcel: empty bit, zeros, address
// - Odd end address advances one word
// - Status read returns word, clears all flags but par and bpar
module hippi_dest_status #(
   parameter int ADDR_W = 13,
   parameter bit WIDE_CAPABLE = 1'b1,
   parameter bit IS_MASTER = 1'b1
) (
   // System clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // Link pins, sampled on link_clk
   input wire logic link_clk,
   input wire logic request,
   input wire logic packet,
   input wire logic burst,
   input wire logic [31:0] data,
   input wire logic [3:0] parity,
   output logic connect,
   // Cable-B interconnect
   input wire logic icb_in,
   output logic icb_out,
   // Foreground function port
   input wire logic cmd_valid,
   input wire logic [`FN_W-1:0] cmd_code,
   input wire logic [15:0] cmd_parm,
   output logic rsp_valid,
   output logic [31:0] rsp_data,
   // Data path status
   input wire logic src_clear,
   input wire logic bstk_par_err,
   input wire logic [4:0] fifo_parcels,
   input wire logic buf_busy,
   output logic [ADDR_W-1:0] buf_addr,
   output logic irq
);
   generate
      if (ADDR_W < 2 || ADDR_W > 13) begin : g_bad
         $error("ADDR_W must lie in 2..13");
      end
   endgenerate

   // Link domain
   logic lrst_s1, lrst_q;
   logic req_q, pkt_q, bur_q, pkt_p, bur_p;
   logic [31:0] dat_q, acc_q;
   logic [3:0] par_q;
   logic [8:0] blen_q;
   logic short_q;
   logic conn_l, conn_pin_q;
   hippi_dest_pkg::link_evt_t ev_q, ev_chg;
   logic par_bad, burst_fell, pkt_fell, seq_any, seq_hard;

   // Reset carried into the link domain
   always_ff @(posedge link_clk) begin
      lrst_s1 <= srst;
      lrst_q <= lrst_s1;
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         req_q <= 1'b0;
         pkt_q <= 1'b0;
         bur_q <= 1'b0;
         pkt_p <= 1'b0;
         bur_p <= 1'b0;
         dat_q <= 32'h0000_0000;
         par_q <= 4'h0;
      end else begin
         req_q <= request;
         pkt_q <= packet;
         bur_q <= burst & packet;
         pkt_p <= pkt_q;
         bur_p <= bur_q;
         dat_q <= data;
         par_q <= parity;
      end
   end

   always_comb begin
      par_bad = 1'b0;
      for (int i = 0; i < 4; i++) begin
         par_bad = par_bad | ~(^{dat_q[8*i +: 8], par_q[i]});
      end
   end

   assign burst_fell = bur_p & ~bur_q;
   assign pkt_fell = pkt_p & ~pkt_q;
   // Raw burst pin used so burst without packet is still seen
   always_comb begin
      seq_hard = ((pkt_q | bur_q) & ~req_q) | (burst & ~packet);
      seq_any = seq_hard | ((pkt_q | bur_q) & ~conn_l)
         | (pkt_q & bur_q & ~pkt_p & ~bur_p)
         | (pkt_p & bur_p & ~pkt_q & ~bur_q & req_q);
   end

   // LLRC accumulation and burst length
   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         acc_q <= 32'h0000_0000;
         blen_q <= 9'h000;
      end else if (bur_q) begin
         acc_q <= bur_p ? (acc_q ^ dat_q) : dat_q;
         blen_q <= bur_p ? blen_q + ((blen_q > `LONG_BURST) ? 9'h000
            : 9'h001) : 9'h001;
      end
   end

   always_ff @(posedge link_clk) begin
      if (lrst_q || pkt_fell) begin
         short_q <= 1'b0;
      end else if (burst_fell && blen_q < `LONG_BURST) begin
         short_q <= 1'b1;
      end
   end

   // Each event flips its own toggle
   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         ev_q <= '0;
      end else begin
         ev_q.word <= ev_q.word ^ bur_q;
         ev_q.burst_end <= ev_q.burst_end ^ burst_fell;
         ev_q.pkt_end <= ev_q.pkt_end ^ pkt_fell;
         ev_q.par_err <= ev_q.par_err ^ ((bur_q | bur_p) & par_bad);
         ev_q.seq_err <= ev_q.seq_err ^ seq_any;
         ev_q.seq_fatal <= ev_q.seq_fatal ^ seq_hard;
         ev_q.llrc_err <= ev_q.llrc_err
            ^ (burst_fell & (dat_q != acc_q));
         ev_q.long_err <= ev_q.long_err
            ^ (bur_q & blen_q == `LONG_BURST);
         ev_q.short_err <= ev_q.short_err
            ^ (burst_fell & short_q & blen_q < `LONG_BURST);
      end
   end

   // Connect leaves on the link edge
   always_ff @(posedge link_clk) begin
      if (lrst_q) begin
         conn_pin_q <= 1'b0;
      end else begin
         conn_pin_q <= conn_l;
      end
   end
   assign connect = conn_pin_q;

   // System domain
   logic conn_q, wide_q, loop_q, irq_q, half_q;
   logic req_l, pkt_l, req_chg, icb_l;
   logic rsp_valid_q;
   logic [31:0] rsp_q;
   logic [5:0] pend_q, rdy_q, rp_q, wp_q;
   logic [6:0] rdy_sum;
   logic [ADDR_W-1:0] addr_q, addr_end;
   logic [ADDR_W-1:0] qmem [0:63];
   hippi_dest_pkg::flags_t flags_q, fset, fclr;
   logic fn_clear, fn_cap, fn_acc, fn_disc, fn_plog, fn_pop;
   logic fn_stat, fn_load, fn_rdy;
   logic push, pop, conn_rise, fatal, disc_ev, lost;
   logic [31:0] status;
   logic [10:0] sync_lvl, sync_chg;

   cross_sync #(.W(11)) u_link_to_sys (
      .clk(clk_sys),
      .rst(srst),
      .d({ev_q, req_q, pkt_q}),
      .lvl(sync_lvl),
      .chg(sync_chg)
   );
   // Event toggles only matter as changes, levels only for the pins
   assign {ev_chg, req_chg} = sync_chg[10:1];
   assign {req_l, pkt_l} = sync_lvl[1:0];

   cross_sync #(.W(1)) u_icb (
      .clk(clk_sys),
      .rst(srst),
      .d(icb_in),
      .lvl(icb_l),
      .chg()
   );

   cross_sync #(.W(1)) u_conn_to_link (
      .clk(link_clk),
      .rst(lrst_q),
      .d(conn_q),
      .lvl(conn_l),
      .chg()
   );

   always_comb begin
      fn_clear = cmd_valid && cmd_code == `FN_CLEAR;
      fn_cap = cmd_valid && cmd_code == `FN_CAPTURE;
      fn_acc = cmd_valid && cmd_code == `FN_ACCEPT;
      fn_disc = cmd_valid && cmd_code == `FN_DISCONNECT;
      fn_plog = cmd_valid && cmd_code == `FN_PARLOG_READ;
      fn_pop = cmd_valid && cmd_code == `FN_QUEUE_POP;
      fn_stat = cmd_valid && cmd_code == `FN_STATUS_READ;
      fn_load = cmd_valid && cmd_code == `FN_ADDR_LOAD;
      fn_rdy = cmd_valid && cmd_code == `FN_READY_REQ;
   end

   // Commands are not held off while link data flows
   always_comb begin
      lost = ((fn_cap | fn_acc) & (~req_l | conn_q))
         | (fn_disc & ~conn_q)
         | (fn_load & rdy_q != 6'h00)
         | (fn_rdy & ~conn_q);
   end

   assign conn_rise = fn_acc & req_l & ~conn_q;
   assign disc_ev = req_chg & ~req_l & conn_q;
   assign push = ev_chg.pkt_end & pend_q != `PEND_MAX;
   assign pop = fn_pop & pend_q != 6'h00;

   always_comb begin
      fset = '0;
      fset.qovf = ev_chg.pkt_end & pend_q == `PEND_MAX;
      fset.seq = ev_chg.seq_err;
      fset.llrc = ev_chg.llrc_err;
      fset.par = ev_chg.par_err;
      fset.long_b = ev_chg.long_err;
      fset.short_b = ev_chg.short_err;
      fset.disc = disc_ev;
      fset.bpar = bstk_par_err;
      fset.fovf = ev_chg.word & fifo_parcels == `FIFO_LIMIT
         & buf_busy;
      fset.lost = lost;
      fclr = fn_stat ? '1 : '0;
      fclr.par = fn_plog;
      fclr.bpar = fn_plog;
   end

   always_comb begin
      fatal = fset.qovf | fset.par | fset.llrc | fset.long_b
         | fset.short_b | fset.disc | fset.fovf
         | ev_chg.seq_fatal;
   end

   // Set beats a read clear in the same cycle; controller clear beats set
   always_ff @(posedge clk_sys) begin
      if (srst || fn_clear) begin
         flags_q <= '0;
      end else begin
         flags_q <= (flags_q & ~fclr) | fset;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || fn_clear || fatal || fn_disc) begin
         conn_q <= 1'b0;
      end else if (conn_rise) begin
         conn_q <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         wide_q <= 1'b0;
         loop_q <= 1'b0;
      end else if (fn_clear) begin
         wide_q <= cmd_parm[`CLR_WIDE_BIT];
         loop_q <= cmd_parm[`CLR_LOOP_BIT] & ~src_clear;
      end else if (src_clear) begin
         loop_q <= 1'b0;
      end
   end
   assign icb_out = wide_q;

   // Buffer address: words advance it, odd end rounds it up
   always_comb begin
      addr_end = addr_q + (ev_chg.word ? ADDR_W'(1) : ADDR_W'(0));
   end

   always_ff @(posedge clk_sys) begin
      if (srst || fn_clear || conn_rise) begin
         addr_q <= '0;
      end else if (fn_load && !lost) begin
         addr_q <= cmd_parm[ADDR_W-1:0];
      end else if (ev_chg.pkt_end && addr_end[0]) begin
         addr_q <= addr_end + ADDR_W'(1);
      end else begin
         addr_q <= addr_end;
      end
   end
   assign buf_addr = addr_q;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         half_q <= 1'b0;
      end else begin
         half_q <= addr_q[ADDR_W-1];
      end
   end

   // End-address queue
   always_ff @(posedge clk_sys) begin
      if (push) begin
         qmem[wp_q] <= addr_end;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || fn_clear || conn_rise) begin
         wp_q <= 6'h00;
         rp_q <= 6'h00;
      end else begin
         wp_q <= wp_q + (push ? 6'h01 : 6'h00);
         rp_q <= rp_q + (pop ? 6'h01 : 6'h00);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || fn_clear || conn_rise) begin
         pend_q <= 6'h00;
      end else begin
         pend_q <= pend_q + (push ? 6'h01 : 6'h00)
            - (pop ? 6'h01 : 6'h00);
      end
   end

   // Ready count
   always_comb begin
      rdy_sum = {1'b0, rdy_q};
      if (fn_rdy && !lost) begin
         rdy_sum = rdy_sum + {1'b0, cmd_parm[5:0]};
      end
      if (rdy_sum > {1'b0, `RDY_MAX}) begin
         rdy_sum = {1'b0, `RDY_MAX};
      end
      if (ev_chg.burst_end && rdy_sum != 7'h00) begin
         rdy_sum = rdy_sum - 7'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst || fn_clear || conn_rise) begin
         rdy_q <= 6'h00;
      end else begin
         rdy_q <= rdy_sum[5:0];
      end
   end

   // A read clear never hides an event of the same cycle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= (irq_q & ~(fn_clear | fn_stat)) | fatal | fset.seq
            | req_chg
            | push
            | (half_q != addr_q[ADDR_W-1]);
      end
   end
   assign irq = irq_q;

   // Status word
   always_comb begin
      status = 32'h0000_0000;
      status[`ST_LOOP] = loop_q;
      status[`ST_WIDE] = wide_q;
      status[`ST_QOVF] = flags_q.qovf;
      status[`ST_HI_ERR] = WIDE_CAPABLE ? flags_q.seq : flags_q.par;
      status[`ST_LO_ERR] = WIDE_CAPABLE ? flags_q.par : flags_q.seq;
      status[`ST_LLRC] = flags_q.llrc;
      status[`ST_LONG] = flags_q.long_b;
      status[`ST_SHORT] = flags_q.short_b;
      status[`ST_DISC] = flags_q.disc;
      status[`ST_BPAR] = flags_q.bpar;
      status[`ST_FOVF] = flags_q.fovf;
      status[`ST_LOST] = flags_q.lost;
      status[`ST_PACKET] = pkt_l;
      status[`ST_CONNECT] = conn_q;
      status[`ST_REQUEST] = req_l;
      status[`ST_ICB] = IS_MASTER & icb_l;
      status[`ST_CAPABLE] = WIDE_CAPABLE;
      status[`ST_HALF] = addr_q[ADDR_W-1];
      status[`ST_PEND_LSB +: 6] = pend_q;
      status[`ST_RDY_LSB +: 6] = rdy_q;
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         rsp_valid_q <= 1'b0;
         rsp_q <= 32'h0000_0000;
      end else begin
         rsp_valid_q <= fn_stat | fn_pop | fn_plog;
         if (fn_stat) begin
            rsp_q <= status;
         end else if (fn_pop) begin
            rsp_q <= 32'h0000_0000;
            rsp_q[`QE_EMPTY] <= pend_q == 6'h00;
            rsp_q[ADDR_W-1:0] <= qmem[rp_q];
         end else if (fn_plog) begin
            rsp_q <= 32'h0000_0000;
            rsp_q[`ST_HI_ERR] <= flags_q.par;
            rsp_q[`ST_BPAR] <= flags_q.bpar;
         end
      end
   end
   assign rsp_valid = rsp_valid_q;
   assign rsp_data = rsp_q;
endmodule
`default_nettype wire

// *** hdl/hippi_dest_map.svh ***
// Constants of the destination status and end-address queue block.
// Assumes inclusion by bare name from the design, checker and bench files.
`ifndef HIPPI_DEST_MAP_SVH
`define HIPPI_DEST_MAP_SVH
// Function codes, decimal numbering of the controller functions
`define FN_W 5
`define FN_CLEAR 5'h00
`define FN_CAPTURE 5'h01
`define FN_ACCEPT 5'h02
`define FN_DISCONNECT 5'h03
`define FN_PARLOG_READ 5'h04
`define FN_QUEUE_POP 5'h06
`define FN_STATUS_READ 5'h07
`define FN_ADDR_LOAD 5'h0c
`define FN_READY_REQ 5'h0d
// Controller clear parameter bits
`define CLR_WIDE_BIT 0
`define CLR_LOOP_BIT 1
// Status word positions
`define ST_LOOP 31
`define ST_WIDE 30
`define ST_QOVF 27
`define ST_HI_ERR 26
`define ST_LLRC 25
`define ST_LO_ERR 24
`define ST_LONG 23
`define ST_SHORT 22
`define ST_DISC 21
`define ST_BPAR 20
`define ST_FOVF 19
`define ST_LOST 18
`define ST_PACKET 17
`define ST_CONNECT 16
`define ST_REQUEST 15
`define ST_ICB 14
`define ST_CAPABLE 13
`define ST_HALF 12
`define ST_PEND_LSB 6
`define ST_RDY_LSB 0
// Queue entry layout
`define QE_EMPTY 15
// Counts
`define PEND_MAX 6'h3f
`define RDY_MAX 6'h20
`define FIFO_LIMIT 5'h1f
`define LONG_BURST 9'h100
`endif

// *** hdl/hippi_dest_pkg.sv ***
// Types shared by the destination status block.
// Assumes hippi_dest_map.svh for the numbers themselves.
`default_nettype none
package hippi_dest_pkg;
   // Toggles from the link domain, one per event kind
   typedef struct packed {
      logic word;
      logic burst_end;
      logic pkt_end;
      logic par_err;
      logic seq_err;
      logic seq_fatal;
      logic llrc_err;
      logic long_err;
      logic short_err;
   } link_evt_t;
   // Sticky error flags
   typedef struct packed {
      logic qovf;
      logic seq;
      logic llrc;
      logic par;
      logic long_b;
      logic short_b;
      logic disc;
      logic bpar;
      logic fovf;
      logic lost;
   } flags_t;
endpackage
`default_nettype wire

// *** hdl/cross_sync.sv ***
// Three-stage synchroniser with agreement filter and change pulse.
// Assumes d comes from another clock domain or a pin.
`default_nettype none
module cross_sync #(
   parameter int W = 1
) (
   // Clock and reset of the receiving domain
   input wire logic clk,
   input wire logic rst,
   // Crossing signals
   input wire logic [W-1:0] d,
   output logic [W-1:0] lvl,
   output logic [W-1:0] chg
);
   logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, chg_q;

   // First stage feeds only the second
   always_ff @(posedge clk) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= d;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts only once two stages agree
   always_comb begin
      lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lvl_q <= '0;
         chg_q <= '0;
      end else begin
         lvl_q <= lvl_d;
         chg_q <= lvl_d ^ lvl_q;
      end
   end

   assign lvl = lvl_q;
   assign chg = chg_q;
endmodule
`default_nettype wire

// *** dv/hippi_src_model.sv ***
// Link source model: request level, one-burst packets closed by LLRC.
// Assumes go toggles to start a packet and done follows go at the end.
`default_nettype none
module hippi_src_model (
   // Link pins
   input wire logic link_clk,
   input wire logic connect,
   output logic request,
   output logic packet,
   output logic burst,
   output logic [31:0] data,
   output logic [3:0] parity,
   // Bench control
   input wire logic req_en,
   input wire logic go,
   input wire logic [8:0] nwords,
   input wire logic [31:0] seed,
   input wire logic bad_par,
   input wire logic bad_llrc,
   output logic done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] st;
   logic [8:0] cnt;
   logic [31:0] w;
   logic [31:0] acc;
   function automatic logic [3:0] par(input logic [31:0] x);
      for (int i = 0; i < 4; i++) begin
         par[i] = ~^x[8*i+:8];
      end
      par[0] = par[0] ^ bad_par;
   endfunction
   initial begin
      {request, packet, burst, st, cnt, done, parity} = '0;
      {data, w, acc} = '0;
   end
   always @(posedge link_clk) begin
      request <= req_en;
      case (st)
         3'd0: begin
            data <= ~data; // Idle bus never holds its last word
            if (go != done) begin
               packet <= 1'b1;
               cnt <= 9'h0;
               acc <= 32'h0;
               w <= seed;
               st <= 3'd1;
            end
         end
         3'd1: begin
            burst <= 1'b1;
            data <= w;
            parity <= par(w);
            acc <= acc ^ w;
            w <= {w[30:0], w[31] ^ w[21] ^ w[1] ^ w[0]};
            cnt <= cnt + 9'h1;
            if (cnt + 9'h1 == nwords) st <= 3'd2;
         end
         3'd2: begin
            burst <= 1'b0;
            data <= bad_llrc ? ~acc : acc;
            parity <= par(bad_llrc ? ~acc : acc);
            st <= 3'd3;
         end
         3'd3: begin
            packet <= 1'b0;
            data <= ~data;
            st <= 3'd4;
         end
         default: begin
            done <= go;
            st <= 3'd0;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** dv/hippi_dest_status_checker.sv ***
// Port-level assertions for the destination status block.
// Assumes it is bound onto hippi_dest_status below.
`default_nettype none
`include "hippi_dest_map.svh"
module hippi_dest_status_checker #(
   parameter int ADDR_W = 13,
   parameter bit WIDE_CAPABLE = 1'b1
) (
   // Clocks and reset
   input wire logic clk_sys,
   input wire logic srst,
   input wire logic link_clk,
   // Link
   input wire logic request,
   input wire logic connect,
   input wire logic icb_out,
   // Function port
   input wire logic cmd_valid,
   input wire logic [`FN_W-1:0] cmd_code,
   input wire logic rsp_valid,
   input wire logic [31:0] rsp_data,
   // Status outputs
   input wire logic [ADDR_W-1:0] buf_addr,
   input wire logic irq
);
   logic is_ans;
   assign is_ans = cmd_valid && (cmd_code == `FN_PARLOG_READ ||
      cmd_code == `FN_QUEUE_POP || cmd_code == `FN_STATUS_READ);
   sequence s_stat;
      cmd_valid && cmd_code == `FN_STATUS_READ ##1 rsp_valid;
   endsequence
   sequence s_pop;
      cmd_valid && cmd_code == `FN_QUEUE_POP ##1 rsp_valid;
   endsequence
   chk_answer_given:
   assert property (@(posedge clk_sys) disable iff (srst)
      is_ans |=> rsp_valid) else $error("answer missing");
   chk_answer_cause:
   assert property (@(posedge clk_sys) disable iff (srst)
      rsp_valid |-> $past(is_ans)) else $error("answer without command");
   chk_wide_by_clear:
   assert property (@(posedge clk_sys) disable iff (srst)
      $changed(icb_out) |-> $past(cmd_valid && cmd_code == `FN_CLEAR))
      else $error("cable-B out moved without clear");
   chk_status_fixed:
   assert property (@(posedge clk_sys) disable iff (srst)
      s_stat |-> rsp_data[29:28] == 2'b00 &&
      rsp_data[`ST_CAPABLE] == WIDE_CAPABLE) else $error("fixed bits");
   chk_wide_shown:
   assert property (@(posedge clk_sys) disable iff (srst)
      s_stat |-> rsp_data[`ST_WIDE] == icb_out) else $error("wide bit");
   chk_ready_cap:
   assert property (@(posedge clk_sys) disable iff (srst)
      s_stat |-> rsp_data[5:0] <= `RDY_MAX) else $error("ready over cap");
   chk_entry_format:
   assert property (@(posedge clk_sys) disable iff (srst)
      s_pop |-> rsp_data[31:16] == 16'h0 && rsp_data[14:13] == 2'b00)
      else $error("queue entry format");
   chk_disc_drop:
   assert property (@(posedge link_clk) disable iff (srst)
      $fell(request) && connect |-> ##[1:6] !connect)
      else $error("connect held after request fell");
   chk_half_irq:
   assert property (@(posedge clk_sys) disable iff (srst)
      $changed(buf_addr[ADDR_W-1]) && !$past(cmd_valid &&
      cmd_code == `FN_CLEAR) |-> ##[0:3] irq) else $error("half no irq");
endmodule
bind hippi_dest_status hippi_dest_status_checker #(.ADDR_W(ADDR_W),
   .WIDE_CAPABLE(WIDE_CAPABLE)) chk_i (.clk_sys(clk_sys), .srst(srst),
   .link_clk(link_clk), .request(request), .connect(connect),
   .icb_out(icb_out), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .rsp_valid(rsp_valid), .rsp_data(rsp_data), .buf_addr(buf_addr),
   .irq(irq));
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the destination status block.
// Assumes the source model drives the link; functions go through cmd().
`default_nettype none
`include "hippi_dest_map.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys, srst, link_clk, request, packet, burst, connect, icb_in;
   logic icb_out, cmd_valid, rsp_valid, src_clear, bstk_par_err, buf_busy;
   logic irq, req_en, go, done, bad_par, bad_llrc;
   logic [31:0] data, rsp_data, seed, lfsr, got;
   logic [3:0] parity;
   logic [4:0] cmd_code, fifo_parcels;
   logic [15:0] cmd_parm;
   logic [8:0] nwords, n;
   logic [12:0] buf_addr, addr;
   logic [12:0] q[$];
   logic [4:0] lost_c[4] = '{`FN_CAPTURE, `FN_ACCEPT, `FN_DISCONNECT,
      `FN_READY_REQ};
   int err_count, cmp_count;
   hippi_dest_status hippi_dest_status_i (.clk_sys(clk_sys), .srst(srst),
      .link_clk(link_clk), .request(request), .packet(packet),
      .burst(burst), .data(data), .parity(parity), .connect(connect),
      .icb_in(icb_in), .icb_out(icb_out), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .cmd_parm(cmd_parm), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .src_clear(src_clear),
      .bstk_par_err(bstk_par_err), .fifo_parcels(fifo_parcels),
      .buf_busy(buf_busy), .buf_addr(buf_addr), .irq(irq));
   hippi_src_model hippi_src_model_i (.link_clk(link_clk),
      .connect(connect), .request(request), .packet(packet),
      .burst(burst), .data(data), .parity(parity), .req_en(req_en),
      .go(go), .nwords(nwords), .seed(seed), .bad_par(bad_par),
      .bad_llrc(bad_llrc), .done(done));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   initial begin
      link_clk = 1'b0;
      #13;
      forever #40 link_clk = ~link_clk;
   end
   function automatic logic [31:0] nxt(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic int err_bit(input int k);
      case (k)
         0: return `ST_LO_ERR;
         1: return `ST_LLRC;
         2: return `ST_LONG;
         3: return `ST_FOVF;
         default: return `ST_DISC;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [31:0] exp, act);
      cmp_count++;
      if (exp !== act) begin
         err_count++;
         $display("MISMATCH %s exp %h got %h", nm, exp, act);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Bounded wait on connect (sel 0) or the model's done (sel 1)
   task automatic wait_sig(input int sel, input logic v);
      for (int i = 0; i < 8000; i++) begin
         @(posedge clk_sys);
         if ((sel == 1 ? done : connect) === v) return;
      end
      chk($sformatf("wait %0d", sel), {31'h0, v}, {31'h0, ~v});
      wrap_up();
   endtask
   task automatic cmd(input logic [4:0] c, input logic [15:0] p);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_parm <= p;
      @(posedge clk_sys);
      cmd_valid <= 1'b0;
      @(posedge clk_sys);
      got = rsp_data;
   endtask
   task automatic st_bit(input int b, input logic v);
      cmd(`FN_STATUS_READ, 16'h0);
      chk($sformatf("status bit %0d", b), {31'h0, v}, {31'h0, got[b]});
   endtask
   task automatic send(input logic [8:0] k, input logic bp, bl);
      @(posedge clk_sys);
      {nwords, bad_par, bad_llrc, seed} <= {k, bp, bl, lfsr};
      go <= ~go;
      lfsr = nxt(lfsr);
      wait_sig(1, ~go);
   endtask
   task automatic link_up();
      cmd(`FN_CAPTURE, 16'h0);
      cmd(`FN_ACCEPT, 16'h0);
      wait_sig(0, 1'b1);
   endtask
   initial begin
      {err_count, cmp_count, lfsr} = {32'h0, 32'h0, 32'ha394};
      {srst, icb_in, cmd_valid, cmd_code, cmd_parm} = {2'b11, 22'h0};
      {src_clear, bstk_par_err, fifo_parcels, buf_busy, req_en} = '0;
      {go, nwords, seed, bad_par, bad_llrc} = {1'b0, 9'h1, 34'h4};
      repeat (8) @(posedge link_clk);
      chk("reset outs", 32'h0, {15'h0, connect, icb_out, rsp_valid, irq,
         buf_addr});
      @(posedge clk_sys);
      srst <= 1'b0;
      cmd(`FN_CLEAR, 16'h3);
      chk("icb_out", 32'h1, {31'h0, icb_out});
      cmd(`FN_STATUS_READ, 16'h0);
      chk("loop wide cap", 32'h7, {29'h0, got[31:30], got[13]});
      @(posedge clk_sys);
      src_clear <= 1'b1;
      @(posedge clk_sys);
      src_clear <= 1'b0;
      cmd(`FN_STATUS_READ, 16'h0);
      chk("loop wide", 32'h1, {30'h0, got[31:30]});
      cmd(`FN_CLEAR, 16'h0);
      chk("icb_out", 32'h0, {31'h0, icb_out});
      foreach (lost_c[i]) begin
         cmd(lost_c[i], 16'h5);
         cmd(`FN_STATUS_READ, 16'h0);
         chk("lost rdy", 32'h40, {25'h0, got[`ST_LOST], got[5:0]});
      end
      st_bit(`ST_LOST, 1'b0);
      req_en <= 1'b1;
      repeat (100) @(posedge clk_sys);
      chk("irq", 32'h1, {31'h0, irq});
      cmd(`FN_STATUS_READ, 16'h0);
      chk("con req icb", 32'h3, {29'h0, got[16:14]});
      link_up();
      cmd(`FN_ADDR_LOAD, 16'h0ffe);
      cmd(`FN_READY_REQ, 16'h5);
      cmd(`FN_READY_REQ, 16'h28);
      cmd(`FN_STATUS_READ, 16'h0);
      chk("con pend rdy", 32'h1020, {19'h0, got[16], got[11:0]});
      cmd(`FN_ADDR_LOAD, 16'h0);
      st_bit(`ST_LOST, 1'b1);
      @(posedge clk_sys);
      bstk_par_err <= 1'b1;
      @(posedge clk_sys);
      bstk_par_err <= 1'b0;
      cmd(`FN_STATUS_READ, 16'h0);
      chk("bpar con", 32'h3, {30'h0, got[`ST_BPAR], got[`ST_CONNECT]});
      cmd(`FN_PARLOG_READ, 16'h0);
      chk("parlog bpar", 32'h1, {31'h0, got[`ST_BPAR]});
      st_bit(`ST_BPAR, 1'b0);
      addr = 13'h0ffe;
      repeat (3) begin
         n = {6'h0, lfsr[2:0]} + 9'h1;
         addr = addr + {4'h0, n};
         q.push_back(addr);
         if (addr[0]) addr = addr + 13'h1;
         send(n, 1'b0, 1'b0);
      end
      repeat (60) @(posedge clk_sys);
      chk("irq", 32'h1, {31'h0, irq});
      cmd(`FN_STATUS_READ, 16'h0);
      chk("half pend rdy", {19'h0, addr[12], 12'h0dd},
         {19'h0, got[12:0]});
      for (int i = 0; i < 4; i++) begin
         cmd(`FN_QUEUE_POP, 16'h0);
         chk("entry", i < 3 ? {19'h0, q[i]} : 32'h8000,
            i < 3 ? got : {got[31:13], 13'h0});
      end
      for (int k = 0; k < 5; k++) begin
         link_up();
         if (k == 3) {fifo_parcels, buf_busy} <= {`FIFO_LIMIT, 1'b1};
         if (k == 4) req_en <= 1'b0;
         else send(k == 2 ? 9'h101 : 9'h4, k == 0, k == 1);
         wait_sig(0, 1'b0);
         {fifo_parcels, buf_busy} <= 6'h0;
         repeat (100) @(posedge clk_sys);
         st_bit(err_bit(k), 1'b1);
         if (k == 0) begin
            cmd(`FN_PARLOG_READ, 16'h0);
            chk("parlog link", 32'h1, {31'h0, got[`ST_HI_ERR]});
         end
         st_bit(err_bit(k), 1'b0);
         req_en <= 1'b1;
         repeat (100) @(posedge clk_sys);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
